// ===== alus_params.svh
`ifndef ALUS_PARAMS_SVH
`define ALUS_PARAMS_SVH

// ----------------------------------------------------------------
// instruction field
// ----------------------------------------------------------------
`define ALUS_OP_SUBTRACT_R_FROM_S 4'h2
`define ALUS_OP_SUBTRACT_S_FROM_R 4'h3
`define ALUS_INSTR_SUBTRACT_IMMEDIATE 8'hd8
`define ALUS_SH_PASS 4'he
`define ALUS_SH_SRL 4'h2
`define ALUS_SH_DOUBLE_LOGICAL_RIGHT_SHIFT 4'h3
`define ALUS_SH_CRD 4'h9

// ----------------------------------------------------------------
// byte configuration
// ----------------------------------------------------------------
`define ALUS_CFG_1B 3'h0
`define ALUS_CFG_2B 3'h2
`define ALUS_CFG_4B 3'h6
`define ALUS_START_1B 4'hf
`define ALUS_START_2B 4'h5
`define ALUS_START_4B 4'h1
`define ALUS_TOP_1B 4'hf
`define ALUS_TOP_2B 4'ha
`define ALUS_TOP_4B 4'h8
`define ALUS_TOPW_1B 4'h8
`define ALUS_TOPW_2B 4'hc
`define ALUS_TOPW_4B 4'hf

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ALUS_QUOTIENT_RESET 32'h0000_0000

`endif

// ===== alus_pkg.sv
package alus_pkg;
  typedef logic [31:0] alus_word_t;
  typedef logic [3:0] alus_bytes_t;

  typedef struct packed {
    logic [3:0] shift;
    logic [3:0] op;
  } alus_instr_t;

  typedef struct packed {
    logic zero;
    logic negative;
    logic overflow;
    logic carry;
  } alus_status_t;

  typedef enum logic [1:0] {
    ALUS_SHIFT_PASS,
    ALUS_SHIFT_SRL,
    ALUS_SHIFT_DOUBLE_LOGICAL_RIGHT_SHIFT,
    ALUS_SHIFT_CRD
  } alus_shift_t;

  typedef struct packed {
    alus_word_t quotient_register;
  } alus_state_t;
endpackage

// ===== alus_subtract_status.sv
// Functional notes
// - Carry flag comes from ALU carry-out, taken before any shift.
// - Zero and negative flags look at the post-shift result.
// - Overflow is checked after the ALU stage only, not after the shift.
// - Zero on all-zero top word, negative is MSB, overflow signed, carry out.
// - Immediate subtract takes constant 0..15 from low address lines.
// - Immediate subtract: S plus inverted zero-extended constant plus carry.
// - Carry high gives true difference; immediate ignores shift pins.
// - Reverse subtract computes inverted R plus S plus carry.
// - Forward subtract computes R plus inverted S plus carry.
// - Subtract results feed both ALU and quotient shifters.
// - Upper nibble shift applies same microcycle; pass code leaves as is.
// - Shift select and serial pins act only on the shift stage.
// - Byte e2 with quotient load and carry high stores S minus R.
// - Byte e3 with quotient load and carry high stores R minus S.
// - Double right shift fills one in MSB when top serial pin low.
// - Words of one, two or four bytes; MSB rules per word top.
`include "alus_params.svh"

module alus_subtract_status (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction and configuration
  input wire alus_pkg::alus_instr_t instr,
  input wire logic [2:0] byte_configuration_field,
  input wire logic quotient_load_select,
  // operands
  input wire logic [3:0] operand_addr_low,
  input wire alus_pkg::alus_word_t r_data,
  input wire alus_pkg::alus_word_t s_data,
  input wire logic carry_input,
  // shift control
  input wire logic conditional_shift_select,
  input wire alus_pkg::alus_bytes_t byte_serial_io_n,
  // results
  output alus_pkg::alus_word_t alu_result,
  output alus_pkg::alus_word_t quotient_register,
  output alus_pkg::alus_status_t status
);
  import alus_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  alus_state_t state;
  alus_state_t next_state;
  logic is_subtract_immediate;
  logic is_subtract_r_from_s;
  logic is_subtract_s_from_r;
  alus_shift_t shift_kind;
  logic shift_on;
  alus_bytes_t word_start;
  alus_bytes_t word_top;
  alus_bytes_t top_word;

  assign is_subtract_immediate = (instr == `ALUS_INSTR_SUBTRACT_IMMEDIATE);
  assign is_subtract_r_from_s = !is_subtract_immediate && (instr.op == `ALUS_OP_SUBTRACT_R_FROM_S);
  assign is_subtract_s_from_r = !is_subtract_immediate && (instr.op == `ALUS_OP_SUBTRACT_S_FROM_R);

  // the immediate form owns the whole byte, so no shift rides on it
  // immediate ignores shift
  always_comb begin
    shift_kind = ALUS_SHIFT_PASS;
    if (!is_subtract_immediate) begin
      unique case (instr.shift)
        `ALUS_SH_SRL: shift_kind = ALUS_SHIFT_SRL;
        `ALUS_SH_DOUBLE_LOGICAL_RIGHT_SHIFT: shift_kind = ALUS_SHIFT_DOUBLE_LOGICAL_RIGHT_SHIFT;
        `ALUS_SH_CRD: shift_kind = ALUS_SHIFT_CRD;
        default: shift_kind = ALUS_SHIFT_PASS;
      endcase
    end
  end

  assign shift_on = (shift_kind != ALUS_SHIFT_PASS) &&
                    conditional_shift_select;

  always_comb begin
    unique case (byte_configuration_field)
      `ALUS_CFG_1B: begin
        word_start = `ALUS_START_1B;
        word_top = `ALUS_TOP_1B;
        top_word = `ALUS_TOPW_1B;
      end
      `ALUS_CFG_2B: begin
        word_start = `ALUS_START_2B;
        word_top = `ALUS_TOP_2B;
        top_word = `ALUS_TOPW_2B;
      end
      default: begin
        word_start = `ALUS_START_4B;
        word_top = `ALUS_TOP_4B;
        top_word = `ALUS_TOPW_4B;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // operand steering
  // ----------------------------------------------------------------
  alus_word_t opnd_a;
  alus_word_t opnd_b;

  always_comb begin
    opnd_a = 32'h0000_0000;
    opnd_b = 32'h0000_0000;
    if (is_subtract_immediate) begin
      opnd_a = ~{28'h000_0000, operand_addr_low};
      opnd_b = s_data;
    end else if (is_subtract_r_from_s) begin
      opnd_a = ~r_data;
      opnd_b = s_data;
    end else if (is_subtract_s_from_r) begin
      opnd_a = r_data;
      opnd_b = ~s_data;
    end
  end

  // ----------------------------------------------------------------
  // byte slices: adder, then right shifters
  // ----------------------------------------------------------------
  alus_word_t alu_f;
  alus_word_t alu_sh;
  alus_word_t mq_sh;
  logic [4:0] carry_chain;
  alus_bytes_t byte_ovr;
  logic [32:0] alu_ext;
  logic [32:0] mq_ext;

  assign carry_chain[0] = carry_input;
  assign alu_ext = {1'b0, alu_f};
  assign mq_ext = {1'b0, state.quotient_register};

  // low bit of the word that a top byte closes
  function automatic logic word_lsb(input alus_word_t w,
                                    input logic [2:0] cfg,
                                    input int b);
    logic res;
    res = w[0];
    unique case (cfg)
      `ALUS_CFG_1B: res = w[8 * b];
      `ALUS_CFG_2B: res = w[8 * (b - 1)];
      default: res = w[0];
    endcase
    return res;
  endfunction

  for (genvar b = 0; b < 4; b++) begin : g_byte
    logic cin;
    logic [7:0] low7;
    logic [8:0] sum;
    logic alu_top_in;
    logic mq_top_in;
    logic fill;

    assign cin = word_start[b] ? carry_input : carry_chain[b];
    assign low7 = {1'b0, opnd_a[8*b +: 7]} + {1'b0, opnd_b[8*b +: 7]} +
                  {7'h00, cin};
    assign sum = {1'b0, opnd_a[8*b +: 8]} + {1'b0, opnd_b[8*b +: 8]} +
                 {8'h00, cin};
    assign alu_f[8*b +: 8] = sum[7:0];
    assign carry_chain[b+1] = sum[8];
    assign byte_ovr[b] = low7[7] ^ sum[8];

    assign fill = !byte_serial_io_n[b];

    always_comb begin
      alu_top_in = alu_ext[8*b + 8];
      mq_top_in = mq_ext[8*b + 8];
      if (word_top[b]) begin
        unique case (shift_kind)
          ALUS_SHIFT_CRD: begin
            alu_top_in = word_lsb(state.quotient_register,
                                  byte_configuration_field, b);
            mq_top_in = word_lsb(alu_f, byte_configuration_field, b);
          end
          ALUS_SHIFT_DOUBLE_LOGICAL_RIGHT_SHIFT: begin
            alu_top_in = fill;
            mq_top_in = word_lsb(alu_f, byte_configuration_field, b);
          end
          default: begin
            alu_top_in = fill;
            mq_top_in = 1'b0;
          end
        endcase
      end
    end

    assign alu_sh[8*b +: 8] = {alu_top_in, alu_f[8*b+1 +: 7]};
    assign mq_sh[8*b +: 8] = {mq_top_in,
                              state.quotient_register[8*b+1 +: 7]};
  end

  // ----------------------------------------------------------------
  // result and flags
  // ----------------------------------------------------------------
  // shift in same microcycle
  assign alu_result = shift_on ? alu_sh : alu_f;
  assign quotient_register = state.quotient_register;

  alus_bytes_t byte_zero;
  for (genvar z = 0; z < 4; z++) begin : g_zero
    assign byte_zero[z] = !top_word[z] || (alu_result[8*z +: 8] == 8'h00);
  end

  // flags are combinational so they settle with the result
  // same-cycle flags
  always_comb begin
    status.zero = &byte_zero;
    status.negative = alu_result[31];
    status.carry = carry_chain[4];
    // a right shift cannot leave the signed range, so the shift
    // stage adds nothing to the alu overflow here
    // overflow from alu stage only
    status.overflow = byte_ovr[3];
  end

  // ----------------------------------------------------------------
  // quotient register
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (shift_on && (shift_kind != ALUS_SHIFT_SRL)) begin
      next_state.quotient_register = mq_sh;
    end else if (quotient_load_select &&
                 (shift_kind == ALUS_SHIFT_PASS)) begin
      next_state.quotient_register = alu_f;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state.quotient_register <= `ALUS_QUOTIENT_RESET;
    end else begin
      state <= next_state;
    end
  end
endmodule

// ===== alus_chk_sva.sv
module alus_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // controls
  input wire alus_pkg::alus_instr_t instr,
  input wire logic [2:0] byte_configuration_field,
  input wire logic quotient_load_select,
  input wire logic [3:0] operand_addr_low,
  input wire alus_pkg::alus_word_t r_data,
  input wire alus_pkg::alus_word_t s_data,
  input wire logic carry_input,
  input wire logic conditional_shift_select,
  input wire alus_pkg::alus_bytes_t byte_serial_io_n,
  // results
  input wire alus_pkg::alus_word_t alu_result,
  input wire alus_pkg::alus_word_t quotient_register,
  input wire alus_pkg::alus_status_t status
);
  import alus_pkg::*;
  logic four;
  logic sl;
  logic [32:0] rms;
  logic [32:0] smr;
  // only the full-word layout is modelled here
  assign four = byte_configuration_field == 3'h6;
  assign sl = conditional_shift_select;
  assign rms = {1'b0, r_data} + {1'b0, ~s_data} + 33'(carry_input);
  assign smr = {1'b0, ~r_data} + {1'b0, s_data} + 33'(carry_input);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_zero_flag: assert property (
    four |-> status.zero == (alu_result == 32'h0)) else $error("zero bad");
  chk_neg_after_shift: assert property (
    four |-> status.negative == alu_result[31]) else $error("neg bad");
  chk_qload_rev: assert property (
    four && instr == 8'he2 && quotient_load_select
    |=> quotient_register == $past(smr[31:0])) else $error("e2 bad");
  chk_qload_fwd: assert property (
    four && instr == 8'he3 && quotient_load_select
    |=> quotient_register == $past(rms[31:0])) else $error("e3 bad");
  chk_imm_diff: assert property (
    four && instr == 8'hd8 |-> alu_result ==
    s_data + ~{28'h0, operand_addr_low} + {31'h0, carry_input})
    else $error("imm bad");
  chk_carry_preshift: assert property (
    four && instr == 8'h23 && sl |-> status.carry == rms[32])
    else $error("carry bad");
  chk_fill_one: assert property (
    four && instr.shift == 4'h3 && sl && !byte_serial_io_n[3]
    |-> alu_result[31]) else $error("fill bad");
  chk_double_logical_right_shift_quot: assert property (
    four && instr == 8'h33 && sl |=> quotient_register ==
    {$past(rms[0]), $past(quotient_register[31:1])}) else $error("double_logical_right_shift");
  chk_noshift_sel: assert property (
    four && instr == 8'h32 && !sl |-> alu_result == smr[31:0])
    else $error("select bad");
  chk_ovf_shift: assert property (
    four && instr == 8'h22 && sl |-> status.overflow ==
    (r_data[31] != s_data[31] && smr[31] != s_data[31]))
    else $error("ovr bad");
  cover property (instr == 8'he2 && quotient_load_select);
  cover property (instr == 8'hd8 && carry_input);
  cover property (instr == 8'h33 && sl && !byte_serial_io_n[3]);
endmodule

// ===== alus_ctrl.sv
module alus_ctrl (
  // clock
  input wire logic clk,
  // instruction side
  output alus_pkg::alus_instr_t instr,
  output logic [2:0] cfg,
  output logic qls,
  output logic [3:0] imm,
  output alus_pkg::alus_word_t r,
  output alus_pkg::alus_word_t s,
  output logic cin,
  output logic sel,
  output alus_pkg::alus_bytes_t sio_n
);
  timeunit 1ns;
  timeprecision 1ns;
  import alus_pkg::*;
  initial begin
    {instr, qls, imm, r, s, cin, sel, sio_n} = '0;
    cfg = 3'h6;
  end
  // four-bit constant, carry and shift code
  task automatic issue(input logic [7:0] i, input alus_word_t rv, sv,
    input logic [3:0] iv, input logic c, sl, q, input logic [3:0] so);
    @(negedge clk);
    instr = i;
    r = rv;
    s = sv;
    imm = iv;
    cin = c;
    sel = sl;
    qls = q;
    sio_n = so;
  endtask
  task automatic set_cfg(input logic [2:0] c);
    @(negedge clk);
    cfg = c;
  endtask
endmodule

// ===== alus_tb.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import alus_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  alus_instr_t instr;
  logic [2:0] cfg;
  logic qls, cin, sel;
  logic [3:0] imm;
  alus_bytes_t sio_n;
  alus_word_t r, s, alu_result, quotient_register, mq;
  alus_status_t status;
  int err_total = 0;
  int cmp_count = 0;
  logic [7:0] ops [6] = '{8'he2, 8'he3, 8'h22, 8'h23, 8'h32, 8'h33};
  always #4 clk = ~clk;

  alus_ctrl u_ctrl (.clk, .instr, .cfg, .qls, .imm, .r, .s, .cin, .sel,
    .sio_n);
  alus_subtract_status dut (.clk, .rst, .instr,
    .byte_configuration_field(cfg), .quotient_load_select(qls),
    .operand_addr_low(imm), .r_data(r), .s_data(s), .carry_input(cin),
    .conditional_shift_select(sel), .byte_serial_io_n(sio_n),
    .alu_result, .quotient_register, .status);

  task automatic chk(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // --------------------------------------------------------------
  // reference model, one microcycle
  // --------------------------------------------------------------
  task automatic op(input logic [7:0] i, input alus_word_t rv, sv,
    input logic [3:0] iv, input logic c, sl, q, input logic [3:0] so);
    logic [32:0] f;
    logic [31:0] a, b, y, qn;
    logic v;
    u_ctrl.issue(i, rv, sv, iv, c, sl, q, so);
    a = (i[3:0] == 4'h3) ? rv : sv;
    b = (i == 8'hd8) ? ~{28'h0, iv} : (i[3:0] == 4'h3) ? ~sv : ~rv;
    f = {1'b0, a} + {1'b0, b} + 33'(c);
    v = (a[31] == b[31]) && (f[31] != a[31]);
    y = f[31:0];
    qn = mq;
    if (i != 8'hd8 && sl && i[7:4] inside {4'h2, 4'h3})
      y = {~so[3], f[31:1]};
    if (i[7:4] == 4'h3 && sl)
      qn = {f[0], mq[31:1]};
    if (i[7:4] == 4'he && q)
      qn = f[31:0];
    #2;
    chk(alu_result, y, "result");
    chk({28'h0, status}, {28'h0, y == 0, y[31], v, f[32]}, "flags");
    @(posedge clk);
    #1;
    mq = qn;
    chk(quotient_register, mq, "quotient");
  endtask

  // per-word model for all three layouts; flags come from the top word
  task automatic op_cfg(input logic [2:0] cf, input int nb,
    input logic [7:0] i, input alus_word_t rv, sv, input logic c, sl,
    input logic [3:0] so);
    logic [32:0] f;
    logic [31:0] a, b, g, m, y;
    logic v, cy;
    int lo, hb;
    u_ctrl.set_cfg(cf);
    u_ctrl.issue(i, rv, sv, 4'h0, c, sl, 1'b0, so);
    y = 32'h0;
    g = 32'h0;
    v = 1'b0;
    cy = 1'b0;
    hb = 8 * nb - 1;
    m = (nb == 4) ? 32'hffff_ffff : ((32'h1 << (8 * nb)) - 32'h1);
    for (int w = 0; w < 4 / nb; w++) begin
      lo = 8 * nb * w;
      a = ((i[3:0] == 4'h3) ? rv : ~rv) >> lo;
      b = ((i[3:0] == 4'h3) ? ~sv : sv) >> lo;
      f = {1'b0, a & m} + {1'b0, b & m} + 33'(c);
      v = (a[hb] == b[hb]) && (f[hb] != a[hb]);
      cy = f[8 * nb];
      g = f[31:0] & m;
      if (sl && i[7:4] == 4'h2)
        g = (g >> 1) | ({31'h0, !so[lo / 8 + nb - 1]} << hb);
      y = y | (g << lo);
    end
    #2;
    chk(alu_result, y, "cfg result");
    chk({28'h0, status}, {28'h0, g == 0, g[hb], v, cy}, "cfg flags");
    @(posedge clk);
    #1;
    chk(quotient_register, mq, "cfg quotient");
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    logic [7:0] i;
    mq = 32'h0;
    i = 8'($urandom(32'ha03a));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk(quotient_register, 32'h0, "reset");
    op(8'he2, 32'h150084d0, 32'h4900c350, 4'h1, 1, 1, 1, 4'hf);
    chk(quotient_register, 32'h34003e80, "e2 value");
    op(8'he3, 32'h150084d0, 32'h4900c350, 4'h1, 1, 1, 1, 4'hf);
    chk(quotient_register, 32'hcbffc180, "e3 value");
    op(8'hd8, 32'h0, 32'h4900c350, 4'hc, 1, 1, 0, 4'h0);
    op(8'hd8, 32'h0, 32'h0000000f, 4'hf, 1, 0, 0, 4'hf);
    op(8'h32, 32'h2da8c615, 32'h0, 4'h0, 1, 1, 0, 4'h7);
    op(8'h33, 32'h80000000, 32'h1, 4'h0, 0, 1, 0, 4'h7);
    op(8'h22, 32'h7fffffff, 32'h80000000, 4'h0, 1, 0, 0, 4'h0);
    $display("directed test done");
    op_cfg(3'h0, 1, 8'h22, 32'h80ff0100, 32'h01017f02, 1, 1, 4'h5);
    op_cfg(3'h2, 2, 8'he3, 32'h7fff8000, 32'h80000001, 1, 0, 4'h0);
    op_cfg(3'h6, 4, 8'h23, 32'h0, 32'h1, 1, 1, 4'h0);
    $display("config test done");
    repeat (400) begin
      i = ops[$urandom % 6];
      op(i, $urandom, $urandom, 4'($urandom), 1'($urandom),
        (i[7:4] == 4'he) ? 1'b1 : 1'($urandom), 1'($urandom),
        4'($urandom));
    end
    $display("random test done");
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    mq = 32'h0;
    chk(quotient_register, 32'h0, "second reset");
    op(8'he3, 32'h5, 32'h5, 4'h0, 1, 1, 1, 4'hf);
    $display("reset test done");
    wrap_up();
  end
endmodule

bind alus_subtract_status alus_chk u_chk (.clk, .rst, .instr,
  .byte_configuration_field, .quotient_load_select, .operand_addr_low,
  .r_data, .s_data, .carry_input, .conditional_shift_select,
  .byte_serial_io_n, .alu_result, .quotient_register, .status);
